// File: src/adpcm_cfg_pkg.sv
// shared constants for the serial configuration port
package adpcm_cfg_pkg;
    localparam int ADDR_W         = 6;
    localparam int BYTE_W         = 8;
    localparam int SLOT_W         = 6;
    localparam int SIDES          = 2;
    localparam int SIDE_X         = 1;
    localparam int SIDE_Y         = 0;
    localparam int CMD_SIDE_BIT   = 6;
    localparam int CMD_ADDR_MSB   = 5;
    localparam int CTRL_IDLE_BIT  = 5;
    localparam int CTRL_REINIT_BIT = 4;
    localparam int CTRL_PASS_BIT  = 3;
    localparam int CTRL_LAW_BIT   = 2;
    localparam int CTRL_CODE_BIT  = 0;
    localparam logic [7:0] CTRL_RESET = 8'h20;
    localparam logic [5:0] SLOT_RESET = 6'h00;
    localparam logic [2:0] DATA_BYTES_SHORT = 3'h1;
    localparam logic [2:0] DATA_BYTES_LONG  = 3'h3;
    localparam logic [2:0] DATA_BYTES_OVER  = 3'h4;
    localparam int NARROW_SHIFT   = 2;
    localparam int WIDE_SHIFT     = 3;
    localparam int BITPOS_W       = 9;
    localparam int REINIT_CYCLES  = 16;
    localparam int REINIT_CNT_W   = 5;
    localparam int SYS_CLK_HZ     = 20_000_000;
    localparam int WAKE_TIME_MS   = 200;
    localparam int WAKE_CYCLES    = WAKE_TIME_MS * (SYS_CLK_HZ / 1000);
    localparam int WAKE_CNT_W     = 23;
    typedef enum logic [1:0] {
        TXN_IDLE = 2'b00,
        TXN_ADDR = 2'b01,
        TXN_DATA = 2'b10,
        TXN_SKIP = 2'b11
    } txn_state_type;
endpackage

// File: src/serial_byte_capture.sv
// shifts serial configuration bytes in on the serial clock
`timescale 1ns/1ps
module serial_byte_capture (
    input  wire logic       serial_clock_in,
    input  wire logic       reset_n_in,
    input  wire logic       chip_select_n_in,
    input  wire logic       serial_config_input_in,
    output logic [7:0]      byte_out,
    output logic            byte_toggle_out
);
    // the serial clock stops between writes, so the frame is cleared by chip select itself
    wire        frame_clear_n = reset_n_in & ~chip_select_n_in;
    logic [2:0] bit_count;
    logic [6:0] shift;

    always_ff @(posedge serial_clock_in or negedge frame_clear_n) begin
        if (!frame_clear_n) begin
            bit_count <= 3'h0;
            shift     <= 7'h00;
        end else begin
            bit_count <= bit_count + 3'h1;
            shift     <= {serial_config_input_in, shift[6:1]};
        end
    end

    // byte is held for eight serial clocks, long enough for the toggle to cross
    always_ff @(posedge serial_clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            byte_out        <= 8'h00;
            byte_toggle_out <= 1'b0;
        end else if (bit_count == 3'h7) begin
            byte_out        <= {serial_config_input_in, shift};
            byte_toggle_out <= ~byte_toggle_out;
        end
    end
endmodule // serial_byte_capture

// File: src/slot_engine.sv
// per-side timeslot counter and passthrough data mover
`timescale 1ns/1ps
module slot_engine #(
    parameter int POS_W = adpcm_cfg_pkg::BITPOS_W
) (
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       data_clock_in,
    input  wire logic       frame_sync_in,
    input  wire logic       serial_input_in,
    input  wire logic       wide_slot_in,
    input  wire logic [5:0] in_slot_in,
    input  wire logic [5:0] out_slot_in,
    input  wire logic       drive_enable_in,
    output logic            serial_output_out,
    output logic            serial_output_oe_out
);
    logic [2:0]       meta1;
    logic [2:0]       meta2;
    logic [2:0]       meta3;
    logic             sync_prev;
    logic [POS_W-1:0] bit_pos;
    logic [7:0]       capture;
    logic [7:0]       held;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta1 <= 3'h0;
            meta2 <= 3'h0;
            meta3 <= 3'h0;
        end else begin
            meta1 <= {serial_input_in, frame_sync_in, data_clock_in};
            meta2 <= meta1;
            meta3 <= meta2;
        end
    end

    wire             clk_rise   = meta2[0] & ~meta3[0];
    wire             clk_fall   = ~meta2[0] & meta3[0];
    wire             sync_start = meta2[1] & ~sync_prev;
    wire [POS_W-1:0] next_pos   = sync_start ? {POS_W{1'b0}} : bit_pos + {{(POS_W-1){1'b0}}, 1'b1};
    wire [1:0]       shamt      = wide_slot_in ? 2'(adpcm_cfg_pkg::WIDE_SHIFT) : 2'(adpcm_cfg_pkg::NARROW_SHIFT);
    wire [2:0]       bit_mask   = wide_slot_in ? 3'h7 : 3'h3;
    wire [POS_W-1:0] slot_now   = bit_pos >> shamt;
    wire [POS_W-1:0] slot_next  = next_pos >> shamt;
    wire [2:0]       bit_now    = bit_pos[2:0] & bit_mask;
    wire [2:0]       bit_next   = next_pos[2:0] & bit_mask;
    wire             in_hit     = slot_now == POS_W'(in_slot_in);
    wire             out_hit    = slot_next == POS_W'(out_slot_in);
    wire [2:0]       out_index  = bit_mask - bit_next;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_prev            <= 1'b0;
            bit_pos              <= {POS_W{1'b0}};
            serial_output_out    <= 1'b0;
            serial_output_oe_out <= 1'b0;
        end else if (clk_rise) begin
            sync_prev            <= meta2[1];
            bit_pos              <= next_pos;
            serial_output_out    <= held[out_index];
            serial_output_oe_out <= out_hit & drive_enable_in;
        end else begin
            serial_output_oe_out <= serial_output_oe_out & drive_enable_in;
        end
    end

    // input sampled on the falling edge; a full slot is handed to the output side
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            capture <= 8'h00;
            held    <= 8'h00;
        end else if (clk_fall && in_hit) begin
            capture <= {capture[6:0], meta3[2]};
            if (bit_now == bit_mask) begin
                held <= {capture[6:0], meta3[2]};
            end
        end
    end
endmodule // slot_engine

// File: src/adpcm_serial_config_port.sv
// software-mode register bank fed by the shared three-wire serial port
`timescale 1ns/1ps
module adpcm_serial_config_port #(
    parameter bit NEW_ALGORITHM = 1'b1,
    parameter int WAKE_CYCLES   = adpcm_cfg_pkg::WAKE_CYCLES
) (
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       port_select_strap_in,
    input  wire logic [5:0] strapped_device_address_in,
    input  wire logic       serial_clock_in,
    input  wire logic       serial_config_input_in,
    input  wire logic       chip_select_n_in,
    input  wire logic       x_data_clock_in,
    input  wire logic       x_frame_sync_in,
    input  wire logic       x_serial_input_in,
    input  wire logic       y_data_clock_in,
    input  wire logic       y_frame_sync_in,
    input  wire logic       y_serial_input_in,
    output logic            x_serial_output_out,
    output logic            x_serial_output_oe_out,
    output logic            y_serial_output_out,
    output logic            y_serial_output_oe_out,
    output logic [1:0]      idle_powerdown_out,
    output logic [1:0]      coeff_reinit_out,
    output logic [1:0]      passthrough_out,
    output logic [1:0]      mu_law_out,
    output logic [1:0]      encode_decode_select_out,
    output logic            standby_out,
    output logic            engine_awake_out,
    output logic            update_busy_out
);
    logic [7:0]                  link_byte;
    logic                        link_toggle;
    logic [2:0]                  meta1;
    logic [2:0]                  meta2;
    logic [2:0]                  meta3;
    logic [2:0]                  filtered;
    logic                        filtered_prev_cs;
    logic                        toggle_prev;
    adpcm_cfg_pkg::txn_state_type state;
    adpcm_cfg_pkg::txn_state_type next_state;
    logic                        side;
    logic [2:0]                  data_count;
    logic [7:0]                  staged_ctrl;
    logic [7:0]                  staged_in;
    logic [7:0]                  staged_out;
    logic [1:0]                  idle;
    logic [1:0]                  reinit;
    logic [1:0]                  pass;
    logic [1:0]                  law;
    logic [1:0]                  code;
    logic [5:0]                  in_slot [2];
    logic [5:0]                  out_slot [2];
    logic [adpcm_cfg_pkg::REINIT_CNT_W-1:0] reinit_cnt [2];
    logic                        standby;
    logic                        awake;
    logic                        busy;
    logic [adpcm_cfg_pkg::WAKE_CNT_W-1:0] wake_cnt;

    serial_byte_capture u_capture (
        .serial_clock_in        (serial_clock_in),
        .reset_n_in             (reset_n_in),
        .chip_select_n_in       (chip_select_n_in),
        .serial_config_input_in (serial_config_input_in),
        .byte_out               (link_byte),
        .byte_toggle_out        (link_toggle)
    );

    // three-stage synchronisers; a level counts once stages two and three agree
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta1 <= 3'h1;
            meta2 <= 3'h1;
            meta3 <= 3'h1;
        end else begin
            meta1 <= {link_toggle, port_select_strap_in, chip_select_n_in};
            meta2 <= meta1;
            meta3 <= meta2;
        end
    end

    generate
        for (genvar b = 0; b < 3; b++) begin : g_filter
            always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    filtered[b] <= (b == 0) ? 1'b1 : 1'b0;
                end else if (meta2[b] == meta3[b]) begin
                    filtered[b] <= meta3[b];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            filtered_prev_cs <= 1'b1;
            toggle_prev      <= 1'b0;
        end else begin
            filtered_prev_cs <= filtered[0];
            toggle_prev      <= filtered[2];
        end
    end

    wire software_mode = filtered[1];
    wire txn_start     = filtered_prev_cs & ~filtered[0];
    wire txn_end       = ~filtered_prev_cs & filtered[0];
    // the byte register is stable for eight serial clocks after its toggle
    wire byte_event    = filtered[2] ^ toggle_prev;
    wire addr_match    = link_byte[adpcm_cfg_pkg::CMD_ADDR_MSB:0] == strapped_device_address_in;
    wire commit_short  = (state == adpcm_cfg_pkg::TXN_DATA) && txn_end
                         && (data_count == adpcm_cfg_pkg::DATA_BYTES_SHORT);
    wire commit_long   = (state == adpcm_cfg_pkg::TXN_DATA) && txn_end
                         && (data_count == adpcm_cfg_pkg::DATA_BYTES_LONG);
    wire commit_any    = commit_short | commit_long;

    always_comb begin
        next_state = state;
        unique case (state)
            adpcm_cfg_pkg::TXN_IDLE: begin
                if (txn_start && software_mode) begin
                    next_state = adpcm_cfg_pkg::TXN_ADDR;
                end
            end
            adpcm_cfg_pkg::TXN_ADDR: begin
                if (txn_end) begin
                    next_state = adpcm_cfg_pkg::TXN_IDLE;
                end else if (byte_event) begin
                    next_state = addr_match ? adpcm_cfg_pkg::TXN_DATA : adpcm_cfg_pkg::TXN_SKIP;
                end
            end
            adpcm_cfg_pkg::TXN_DATA: begin
                if (txn_end) begin
                    next_state = adpcm_cfg_pkg::TXN_IDLE;
                end
            end
            adpcm_cfg_pkg::TXN_SKIP: begin
                if (txn_end) begin
                    next_state = adpcm_cfg_pkg::TXN_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= adpcm_cfg_pkg::TXN_IDLE;
            busy  <= 1'b0;
        end else begin
            state <= next_state;
            busy  <= next_state == adpcm_cfg_pkg::TXN_DATA;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            side       <= 1'b0;
            data_count <= 3'h0;
        end else if (state == adpcm_cfg_pkg::TXN_ADDR && byte_event) begin
            side       <= link_byte[adpcm_cfg_pkg::CMD_SIDE_BIT];
            data_count <= 3'h0;
        end else if (state == adpcm_cfg_pkg::TXN_DATA && byte_event
                     && data_count != adpcm_cfg_pkg::DATA_BYTES_OVER) begin
            data_count <= data_count + 3'h1;
        end
    end

    // bytes are staged and only committed when chip select returns high
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            staged_ctrl <= 8'h00;
            staged_in   <= 8'h00;
            staged_out  <= 8'h00;
        end else if (state == adpcm_cfg_pkg::TXN_DATA && byte_event) begin
            unique case (data_count)
                3'h0: staged_ctrl <= link_byte;
                3'h1: staged_in   <= link_byte;
                3'h2: staged_out  <= link_byte;
                default: staged_ctrl <= staged_ctrl;
            endcase
        end
    end

    generate
        for (genvar s = 0; s < adpcm_cfg_pkg::SIDES; s++) begin : g_side
            wire write_side = commit_any && (side == 1'(s));
            wire reinit_done = reinit[s]
                               && reinit_cnt[s] == adpcm_cfg_pkg::REINIT_CNT_W'(adpcm_cfg_pkg::REINIT_CYCLES - 1);

            always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    idle[s] <= adpcm_cfg_pkg::CTRL_RESET[adpcm_cfg_pkg::CTRL_IDLE_BIT];
                    pass[s] <= adpcm_cfg_pkg::CTRL_RESET[adpcm_cfg_pkg::CTRL_PASS_BIT];
                    law[s]  <= adpcm_cfg_pkg::CTRL_RESET[adpcm_cfg_pkg::CTRL_LAW_BIT];
                    code[s] <= adpcm_cfg_pkg::CTRL_RESET[adpcm_cfg_pkg::CTRL_CODE_BIT];
                end else if (write_side) begin
                    idle[s] <= staged_ctrl[adpcm_cfg_pkg::CTRL_IDLE_BIT];
                    pass[s] <= staged_ctrl[adpcm_cfg_pkg::CTRL_PASS_BIT];
                    law[s]  <= staged_ctrl[adpcm_cfg_pkg::CTRL_LAW_BIT];
                    code[s] <= staged_ctrl[adpcm_cfg_pkg::CTRL_CODE_BIT];
                end
            end

            always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    in_slot[s]  <= adpcm_cfg_pkg::SLOT_RESET;
                    out_slot[s] <= adpcm_cfg_pkg::SLOT_RESET;
                end else if (commit_long && side == 1'(s)) begin
                    in_slot[s]  <= staged_in[adpcm_cfg_pkg::SLOT_W-1:0];
                    out_slot[s] <= staged_out[adpcm_cfg_pkg::SLOT_W-1:0];
                end
            end

            // a fresh write of the bit wins over the self-clear
            always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    reinit[s]     <= adpcm_cfg_pkg::CTRL_RESET[adpcm_cfg_pkg::CTRL_REINIT_BIT];
                    reinit_cnt[s] <= '0;
                end else if (write_side && staged_ctrl[adpcm_cfg_pkg::CTRL_REINIT_BIT]) begin
                    reinit[s]     <= 1'b1;
                    reinit_cnt[s] <= '0;
                end else if (reinit_done) begin
                    reinit[s]     <= 1'b0;
                end else if (reinit[s]) begin
                    reinit_cnt[s] <= reinit_cnt[s] + adpcm_cfg_pkg::REINIT_CNT_W'(1);
                end
            end
        end
    endgenerate

    // older variant stays asleep until reset; reset release itself powers up
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            standby  <= 1'b0;
            awake    <= 1'b1;
            wake_cnt <= '0;
        end else begin
            standby <= idle[1] & idle[0];
            if (standby) begin
                awake    <= 1'b0;
                wake_cnt <= '0;
            end else if (!awake && NEW_ALGORITHM) begin
                if (wake_cnt == adpcm_cfg_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1)) begin
                    awake <= 1'b1;
                end else begin
                    wake_cnt <= wake_cnt + adpcm_cfg_pkg::WAKE_CNT_W'(1);
                end
            end
        end
    end

    wire [1:0] drive_enable = ~idle & pass & {2{awake & ~busy}};

    slot_engine u_x_slots (
        .sys_clk_in           (sys_clk_in),
        .reset_n_in           (reset_n_in),
        .data_clock_in        (x_data_clock_in),
        .frame_sync_in        (x_frame_sync_in),
        .serial_input_in      (x_serial_input_in),
        .wide_slot_in         (code[adpcm_cfg_pkg::SIDE_X]),
        .in_slot_in           (in_slot[adpcm_cfg_pkg::SIDE_X]),
        .out_slot_in          (out_slot[adpcm_cfg_pkg::SIDE_X]),
        .drive_enable_in      (drive_enable[adpcm_cfg_pkg::SIDE_X]),
        .serial_output_out    (x_serial_output_out),
        .serial_output_oe_out (x_serial_output_oe_out)
    );

    slot_engine u_y_slots (
        .sys_clk_in           (sys_clk_in),
        .reset_n_in           (reset_n_in),
        .data_clock_in        (y_data_clock_in),
        .frame_sync_in        (y_frame_sync_in),
        .serial_input_in      (y_serial_input_in),
        .wide_slot_in         (code[adpcm_cfg_pkg::SIDE_Y]),
        .in_slot_in           (in_slot[adpcm_cfg_pkg::SIDE_Y]),
        .out_slot_in          (out_slot[adpcm_cfg_pkg::SIDE_Y]),
        .drive_enable_in      (drive_enable[adpcm_cfg_pkg::SIDE_Y]),
        .serial_output_out    (y_serial_output_out),
        .serial_output_oe_out (y_serial_output_oe_out)
    );

    assign idle_powerdown_out       = idle;
    assign coeff_reinit_out         = reinit;
    assign passthrough_out          = pass;
    assign mu_law_out               = law;
    assign encode_decode_select_out = code;
    assign standby_out              = standby;
    assign engine_awake_out         = awake;
    assign update_busy_out          = busy;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    standby_both_idle_a: assert property (
        (idle == 2'b11) |=> standby_out) else $error("standby missing with both sides idle");
    standby_leave_a: assert property (
        (idle != 2'b11) |=> !standby_out) else $error("standby held with a side active");
    address_mismatch_a: assert property (
        (state == adpcm_cfg_pkg::TXN_ADDR && byte_event && !txn_end && !addr_match)
        |=> state == adpcm_cfg_pkg::TXN_SKIP ##1 !update_busy_out) else $error("mismatched write accepted");
    strap_low_block_a: assert property (
        (state == adpcm_cfg_pkg::TXN_IDLE && !software_mode) |=> state == adpcm_cfg_pkg::TXN_IDLE)
        else $error("write started in hardware mode");
    side_control_a: assert property (
        (commit_any && side) |=> idle_powerdown_out[1] == $past(staged_ctrl[5])
        && mu_law_out[1] == $past(staged_ctrl[2]) && $stable(mu_law_out[0])) else $error("control went to wrong side");
    short_keeps_slots_a: assert property (
        commit_short |=> $stable(in_slot[0]) && $stable(in_slot[1]) && $stable(out_slot[0]) && $stable(out_slot[1]))
        else $error("two-byte write changed a slot register");
    reinit_clears_a: assert property (
        $rose(coeff_reinit_out[0]) |-> ##[15:17] !coeff_reinit_out[0]) else $error("reinit bit did not self clear");
    update_floats_a: assert property (
        update_busy_out |=> !x_serial_output_oe_out && !y_serial_output_oe_out) else $error("output driven during update");
    wake_timing_a: assert property (
        $rose(engine_awake_out) |-> $past(wake_cnt) == adpcm_cfg_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1)
        && $past(idle) != 2'b11) else $error("wake not after full delay");
endmodule // adpcm_serial_config_port

// File: testbench/host_port_model.sv
// host model driving the three-wire configuration port
`timescale 1ns/1ps
module host_port_model (
    output logic serial_clock_out,
    output logic serial_config_input_out,
    output logic chip_select_n_out
);
    logic base_clk = 1'b0;
    initial forever #16 base_clk = ~base_clk;
    initial begin
        serial_clock_out = 1'b0;
        serial_config_input_out = 1'b0;
        chip_select_n_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge base_clk);
    endtask
    // serial clock held at a 512 ns period so each phase spans several system clocks
    task automatic send(input logic [31:0] data, input int nbytes);
        chip_select_n_out = 1'b0;
        for (int i = 0; i < nbytes * 8; i++) begin
            tick(4);
            serial_config_input_out = data[i];
            tick(4);
            serial_clock_out = 1'b1;
            tick(8);
            serial_clock_out = 1'b0;
        end
        tick(8);
        chip_select_n_out = 1'b1;
        serial_config_input_out = ~serial_config_input_out;
        tick(16);
    endtask
endmodule // host_port_model

// File: testbench/tb_top.sv
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
module tb_top;
    logic       clk = 1'b0, reset_n = 1'b0, strap = 1'b1, dclk = 1'b0, fsync = 1'b0, sin = 1'b0, s;
    logic [5:0] addr = 6'h00;
    logic [7:0] c, ctrl [2] = '{8'h20, 8'h20};
    wire        sclk, serial_config_input, cs_n, xo, xoe, standby, awake, busy;
    wire  [1:0] idle, reinit, pass, mu, code;
    wire  [2:0] flags = {xoe, awake, ~reinit[0]};
    int         miscompares = 0, checked = 0, seed = 3507, pos = 0;
    int         busy_cycles = 0, mark = 0, data_checks = 0;
    logic [7:0] exp_slot = 8'h00;
    logic       live = 1'b0, armed = 1'b0;
    host_port_model host (.serial_clock_out(sclk), .serial_config_input_out(serial_config_input), .chip_select_n_out(cs_n));
    adpcm_serial_config_port #(.WAKE_CYCLES(20)) dut (.sys_clk_in(clk), .reset_n_in(reset_n),
        .port_select_strap_in(strap), .strapped_device_address_in(addr), .serial_clock_in(sclk),
        .serial_config_input_in(serial_config_input), .chip_select_n_in(cs_n), .x_data_clock_in(dclk),
        .x_frame_sync_in(fsync), .x_serial_input_in(sin), .y_data_clock_in(1'b0), .y_frame_sync_in(1'b0),
        .y_serial_input_in(1'b0), .x_serial_output_out(xo), .x_serial_output_oe_out(xoe),
        .y_serial_output_out(), .y_serial_output_oe_out(), .idle_powerdown_out(idle),
        .coeff_reinit_out(reinit), .passthrough_out(pass), .mu_law_out(mu),
        .encode_decode_select_out(code), .standby_out(standby), .engine_awake_out(awake),
        .update_busy_out(busy));
    initial forever #25 clk = ~clk;
    initial forever #200 dclk = ~dclk;
    // 32-bit frame, sync raised ahead of the rising data clock
    always @(negedge dclk) begin
        if (pos >= 8 && pos < 16) exp_slot = {exp_slot[6:0], sin};
        if (live && armed && pos >= 16 && pos < 24) begin
            data_checks++;
            chk("out enable", 8'h01, {7'h00, xoe});
            chk("pass data", {7'h00, exp_slot[23 - pos]}, {7'h00, xo});
        end
        if (live && armed && pos == 24) chk("out float", 8'h00, {7'h00, xoe});
        // arm only before the input slot, so a whole captured slot is compared
        if (pos == 7) armed = live;
        pos = (pos + 1) % 32;
        fsync <= (pos == 0);
        sin <= $random(seed);
    end
    always @(negedge clk) busy_cycles += (busy === 1'b1);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic side(input int i);
        chk("control", ctrl[i] & 8'h3D, {2'b00, idle[i], reinit[i], pass[i], mu[i], 1'b0, code[i]});
    endtask
    // reserved bits always zero; slot bytes are input 1, output 2
    task automatic wr(input logic x, input logic [7:0] v, input int nb, input logic [5:0] a);
        host.send({8'h02, 8'h01, v, 1'b0, x, a}, nb);
        @(negedge clk);
    endtask
    task automatic await(input int b, input int lim);
        for (int i = 0; i < lim && flags[b] !== 1'b1; i++) @(negedge clk);
        chk("await", 8'h01, {7'h00, flags[b]});
        if (flags[b] !== 1'b1) print_verdict();
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        addr = $random(seed);
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        side(0);
        side(1);
        chk("standby", 8'h01, {7'h00, standby});
        for (int k = 0; k < 8; k++) begin
            c = $random(seed) & 8'h2D;
            s = $random(seed);
            wr(s, c, 2, addr);
            ctrl[s] = c;
            side(0);
            side(1);
        end
        mark = busy_cycles;
        wr(1'b1, 8'h0D, 2, addr ^ 6'h20);
        chk("busy", 8'h00, {7'h00, busy_cycles != mark});
        wr(1'b1, 8'h0D, 3, addr);
        strap = 1'b0;
        repeat (5) @(negedge clk);
        wr(1'b1, 8'h0D, 2, addr);
        strap = 1'b1;
        side(1);
        wr(1'b1, 8'h20, 2, addr);
        wr(1'b0, 8'h30, 2, addr);
        ctrl[1] = 8'h20;
        chk("reinit", 8'h01, {7'h00, reinit[0]});
        await(0, 40);
        chk("standby", 8'h01, {7'h00, standby});
        ctrl[0] = 8'h20;
        mark = busy_cycles;
        wr(1'b1, 8'h09, 4, addr);
        chk("busy", 8'h01, {7'h00, busy_cycles != mark});
        ctrl[1] = 8'h09;
        side(1);
        await(1, 60);
        live = 1'b1;
        await(2, 600);
        repeat (520) @(negedge clk);
        chk("slot checks", 8'h01, {7'h00, data_checks >= 8});
        live = 1'b0;
        // long write to the other side overlaps the driven slot, so floating is exercised
        wr(1'b0, 8'h24, 4, addr);
        ctrl[0] = 8'h24;
        side(0);
        print_verdict();
    end
endmodule // tb_top
